// *** hdl/alz_pkg.sv ***
// Purpose: Shared constants for the angle linearize and zero offset block
// Assumes: 12-bit angle, 32-bit AHB-Lite register bus
// Notes:   Offsets are byte addresses of aligned words
package alz_pkg;
    localparam int ANG_W      = 12;
    localparam int SEG_N      = 16;
    localparam int SEG_B      = 4;
    localparam int HARM_N     = 11;
    localparam int COEF_W     = 12;
    localparam int ZOFF_W     = 13;
    localparam int ZOFF_MSB   = 12;
    localparam int ZOFF_LSB   = 0;
    localparam int NVM_ZOFF_WORD = 12'h306;
    // Register map
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_RAW    = 12'h004;
    localparam logic [11:0] OFS_RESULT = 12'h008;
    localparam logic [11:0] OFS_ZOFF   = 12'h00c;
    localparam logic [11:0] OFS_SEG    = 12'h100;
    localparam logic [11:0] OFS_HAMP   = 12'h200;
    localparam logic [11:0] OFS_HPH    = 12'h300;
    localparam logic [11:0] OFS_HOFS   = 12'h3c0;
    localparam int CTRL_MODE_BIT  = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int STAT_BUSY_BIT  = 8;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
    typedef enum logic [3:0] {
        ALZ_IDLE = 4'h1,
        ALZ_ERR  = 4'h2,
        ALZ_LIN  = 4'h4,
        ALZ_ZERO = 4'h8
    } alz_state_t;
endpackage

// *** hdl/alz_harm_term.sv ***
// Purpose: One harmonic correction term, amplitude times a triangular wave
// Assumes: Phase and angle in full-scale codes; amplitude signed
// Notes:   Triangle shaping stands in for a sine table to save area
`timescale 1ns/10ps
module alz_harm_term #(
    parameter int ANG_W  = 12,
    parameter int COEF_W = 12,
    parameter int ORDER  = 1
) (
    input  wire logic [ANG_W-1:0]  angle,
    input  wire logic [COEF_W-1:0] amp,
    input  wire logic [ANG_W-1:0]  phase,
    output logic signed [ANG_W+COEF_W:0] term
);
    localparam logic signed [ANG_W:0] HALF = (ANG_W+1)'(1 << (ANG_W-1));
    logic [ANG_W-1:0]        arg;
    logic signed [ANG_W:0]   tri_w;
    logic [ANG_W+7:0]        prod;
    always_comb begin
        prod  = (ANG_W+8)'(angle) * (ANG_W+8)'(ORDER);
        arg   = prod[ANG_W-1:0] + phase;
        tri_w = arg[ANG_W-1] ? (ANG_W+1)'({1'b0, ~arg[ANG_W-2:0], 1'b0}) - HALF
                             : (ANG_W+1)'({1'b0, arg[ANG_W-2:0], 1'b0}) - HALF;
        term  = (ANG_W+COEF_W+1)'(tri_w * $signed(amp));
    end
endmodule

// *** hdl/alz_core.sv ***
// Purpose: Angle linearization (segmented or harmonic) then zero offset
// Assumes: Nonvolatile values arrive once after reset on nvm_* ports
// Notes:   Result is computed over three cycles after a start
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module alz_core #(
    parameter int ANG_W  = alz_pkg::ANG_W,
    parameter int HARM_N = alz_pkg::HARM_N
) (
    input  wire logic                     clock,
    input  wire logic                     rst,
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output logic [31:0]                   hrdata,
    output logic                          hreadyout,
    output logic                          hresp,
    input  wire logic                     nvm_we,
    input  wire logic [11:0]              nvm_addr,
    input  wire logic [15:0]              nvm_data,
    input  wire logic                     raw_valid,
    input  wire logic [ANG_W-1:0]         raw_angle,
    output logic [ANG_W-1:0]              angle_out,
    output logic                          angle_valid
);
    localparam int CW = alz_pkg::COEF_W;
    localparam int TW = ANG_W + CW + 1;
    localparam int SEG_B_L = alz_pkg::SEG_B;
    ////////////////////////////////////////////////////////////////////////////
    // Coefficient storage, written by NVM load or the bus
    logic [CW-1:0] seg_pt [alz_pkg::SEG_N+1];
    logic [CW-1:0] h_amp  [HARM_N];
    logic [CW-1:0] h_ph   [HARM_N];
    logic [ANG_W-1:0] h_ofs;
    logic [alz_pkg::ZOFF_W-1:0] zoff;
    logic mode_harm;
    logic [ANG_W-1:0] raw_q, lin_q, result;
    alz_pkg::alz_state_t state, next_state;
    // Bus address phase capture
    logic        ap_wr, ap_rd;
    logic [11:0] ap_addr;
    logic        wr_go;
    assign wr_go  = ap_wr;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ap_wr   <= 1'b0;
            ap_rd   <= 1'b0;
            ap_addr <= 12'h000;
        end else if (hready) begin
            ap_wr   <= hsel && htrans[1] && hwrite;
            ap_rd   <= hsel && htrans[1] && !hwrite;
            ap_addr <= haddr[11:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Storage writes; bus after NVM so a runtime write overrides it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i <= alz_pkg::SEG_N; i++) seg_pt[i] <= CW'(i << (ANG_W - SEG_B_L));
            for (int i = 0; i < HARM_N; i++) begin
                h_amp[i] <= '0;
                h_ph[i]  <= '0;
            end
            h_ofs     <= '0;
            zoff      <= '0;
            mode_harm <= 1'b0;
        end else begin
            if (nvm_we && nvm_addr == 12'(alz_pkg::NVM_ZOFF_WORD))
                zoff <= nvm_data[alz_pkg::ZOFF_MSB:alz_pkg::ZOFF_LSB];
            if (nvm_we && nvm_addr[11:8] == 4'h1 && nvm_addr[7:0] <= 8'd16)
                seg_pt[nvm_addr[4:0]] <= nvm_data[CW-1:0];
            if (nvm_we && nvm_addr[11:8] == 4'h2 && nvm_addr[7:0] < 8'(HARM_N))
                h_amp[nvm_addr[3:0]] <= nvm_data[CW-1:0];
            // Phases load from 0x380 up so the offset word cannot alias a phase
            if (nvm_we && nvm_addr[11:4] == 8'h38 && nvm_addr[3:0] < 4'(HARM_N))
                h_ph[nvm_addr[3:0]] <= nvm_data[CW-1:0];
            if (wr_go) begin
                if (ap_addr == alz_pkg::OFS_CTRL)
                    mode_harm <= hwdata[alz_pkg::CTRL_MODE_BIT];
                if (ap_addr == alz_pkg::OFS_ZOFF)
                    zoff <= hwdata[alz_pkg::ZOFF_W-1:0];
                if (ap_addr == alz_pkg::OFS_HOFS)
                    h_ofs <= hwdata[ANG_W-1:0];
                if (ap_addr[11:8] == 4'h1 && ap_addr[7:2] <= 6'd16)
                    seg_pt[ap_addr[6:2]] <= hwdata[CW-1:0];
                if (ap_addr[11:8] == 4'h2 && ap_addr[7:2] < 6'(HARM_N))
                    h_amp[ap_addr[5:2]] <= hwdata[CW-1:0];
                if (ap_addr[11:8] == 4'h3 && ap_addr[7:2] < 6'(HARM_N))
                    h_ph[ap_addr[5:2]] <= hwdata[CW-1:0];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Harmonic error factors, one term per order
    logic signed [TW-1:0] terms [HARM_N];
    for (genvar g = 0; g < HARM_N; g++) begin : g_harm
        alz_harm_term #(.ANG_W(ANG_W), .COEF_W(CW), .ORDER(g + 1)) u_term (
            .angle (raw_q),
            .amp   (h_amp[g]),
            .phase (h_ph[g]),
            .term  (terms[g])
        );
    end
    logic signed [TW+3:0] err_sum;
    logic signed [TW+3:0] err_q, next_err;
    logic [ANG_W-1:0] harm_lin, seg_lin, next_lin;
    logic [SEG_B_L-1:0] seg;
    logic [ANG_W-SEG_B_L-1:0] frac;
    logic signed [CW+1:0] span;
    logic signed [CW+ANG_W:0] step;
    always_comb begin
        err_sum = '0;
        for (int i = 0; i < HARM_N; i++) err_sum = err_sum + (TW+4)'(terms[i]);
        next_err = err_sum;
        // Offset h_ofs subtracted from the angle after the error is scaled into the correction factor
        harm_lin = raw_q - ANG_W'(err_q >>> (ANG_W - 1)) - h_ofs;
        // Segment by top bits, interpolate with the remainder
        seg  = raw_q[ANG_W-1 -: SEG_B_L];
        frac = raw_q[ANG_W-SEG_B_L-1:0];
        span = (CW+2)'(seg_pt[seg + 5'd1]) - (CW+2)'(seg_pt[seg]);
        step = (CW+ANG_W+1)'(span * $signed({1'b0, frac}));
        seg_lin = seg_pt[seg] + ANG_W'(step >>> (ANG_W - SEG_B_L));
        next_lin = mode_harm ? harm_lin : seg_lin;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: capture, error factors, linearize, zero offset
    always_comb begin
        case (state)
            alz_pkg::ALZ_IDLE: next_state = raw_valid ? alz_pkg::ALZ_ERR : alz_pkg::ALZ_IDLE;
            alz_pkg::ALZ_ERR:  next_state = alz_pkg::ALZ_LIN;
            alz_pkg::ALZ_LIN:  next_state = alz_pkg::ALZ_ZERO;
            alz_pkg::ALZ_ZERO: next_state = alz_pkg::ALZ_IDLE;
            default:           next_state = alz_pkg::ALZ_IDLE;
        endcase
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= alz_pkg::ALZ_IDLE;
            raw_q <= '0;
            err_q <= '0;
            lin_q <= '0;
            result <= '0;
            angle_valid <= 1'b0;
        end else begin
            state <= next_state;
            angle_valid <= (state == alz_pkg::ALZ_ZERO);
            if (state == alz_pkg::ALZ_IDLE && raw_valid) raw_q <= raw_angle;
            if (state == alz_pkg::ALZ_ERR) err_q <= next_err;
            if (state == alz_pkg::ALZ_LIN) lin_q <= next_lin;
            // Truncation to ANG_W gives the modulo wrap for free
            if (state == alz_pkg::ALZ_ZERO) result <= lin_q - zoff[ANG_W-1:0];
        end
    end
    assign angle_out = result;
    ////////////////////////////////////////////////////////////////////////////
    // Read mux
    always_comb begin
        hrdata = 32'h0000_0000;
        if (ap_rd) begin
            case (ap_addr)
                alz_pkg::OFS_CTRL:   hrdata = {23'h0, state != alz_pkg::ALZ_IDLE, 7'h0, mode_harm};
                alz_pkg::OFS_RAW:    hrdata = 32'(raw_q);
                alz_pkg::OFS_RESULT: hrdata = 32'(result);
                alz_pkg::OFS_ZOFF:   hrdata = 32'(zoff);
                alz_pkg::OFS_HOFS:   hrdata = 32'(h_ofs);
                default: begin
                    if (ap_addr[11:8] == 4'h1 && ap_addr[7:2] <= 6'd16)
                        hrdata = 32'(seg_pt[ap_addr[6:2]]);
                    else if (ap_addr[11:8] == 4'h2 && ap_addr[7:2] < 6'(HARM_N))
                        hrdata = 32'(h_amp[ap_addr[5:2]]);
                    else if (ap_addr[11:8] == 4'h3 && ap_addr[7:2] < 6'(HARM_N))
                        hrdata = 32'(h_ph[ap_addr[5:2]]);
                end
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    a_zero_after_lin: assert property (@(posedge clock) disable iff (rst)
        state == alz_pkg::ALZ_ZERO |=> result == $past(lin_q) - $past(zoff[ANG_W-1:0]))
        else $error("result not lin minus offset");
    a_zero_nvm_load: assert property (@(posedge clock) disable iff (rst)
        nvm_we && nvm_addr == 12'(alz_pkg::NVM_ZOFF_WORD)
        && !(wr_go && ap_addr == alz_pkg::OFS_ZOFF)
        |=> zoff == $past(nvm_data[alz_pkg::ZOFF_MSB:alz_pkg::ZOFF_LSB]))
        else $error("offset not loaded");
    a_order_seq: assert property (@(posedge clock) disable iff (rst)
        state == alz_pkg::ALZ_IDLE && raw_valid |=> ##2 angle_valid == 1'b0 ##1 angle_valid)
        else $error("pipeline order broken");
    a_mode_select: assert property (@(posedge clock) disable iff (rst)
        state == alz_pkg::ALZ_LIN && !mode_harm |=> lin_q == $past(seg_lin))
        else $error("segment path not chosen");
    a_seg_endpoint: assert property (@(posedge clock) disable iff (rst)
        state == alz_pkg::ALZ_LIN && !mode_harm && frac == '0 |=> lin_q == $past(seg_pt[seg]))
        else $error("segment endpoint wrong");
    a_harm_sum: assert property (@(posedge clock) disable iff (rst)
        state == alz_pkg::ALZ_ERR |=> err_q == $past(err_sum))
        else $error("harmonic sum not taken");
    a_harm_order: assert property (@(posedge clock) disable iff (rst)
        state == alz_pkg::ALZ_LIN && mode_harm |=> lin_q == $past(harm_lin))
        else $error("harmonic path wrong");
    a_bus_override: assert property (@(posedge clock) disable iff (rst)
        wr_go && ap_addr == alz_pkg::OFS_SEG |=> seg_pt[0] == $past(hwdata[CW-1:0]))
        else $error("runtime override lost");
    a_valid_pulse: assert property (@(posedge clock) disable iff (rst)
        angle_valid |=> !angle_valid) else $error("valid not a pulse");
    c_seg_run: cover property (@(posedge clock) angle_valid && !mode_harm);
    c_harm_run: cover property (@(posedge clock) angle_valid && mode_harm);
    c_override: cover property (@(posedge clock) wr_go && ap_addr == alz_pkg::OFS_ZOFF);
    c_wrap: cover property (@(posedge clock)
        state == alz_pkg::ALZ_ZERO && lin_q < zoff[ANG_W-1:0]);
endmodule

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the angle linearize and zero offset core
// Assumes: Zero wait AHB-Lite slave, result four edges after a taken sample
// Notes:   Even fractions only, so interpolation rounding never matters
`timescale 1ns/10ps
module tb_top;
    logic        clock;
    logic        rst;
    logic        hsel;
    logic        hwrite;
    logic        nvm_we;
    logic        raw_valid;
    logic        hreadyout;
    logic        hresp;
    logic        angle_valid;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [11:0] nvm_addr;
    logic [11:0] raw_angle;
    logic [11:0] angle_out;
    logic [11:0] x;
    logic [15:0] nvm_data;
    logic [11:0] q[$];
    int          pts[17];
    int          mode;
    int          off;
    int          hc;
    int          miscompares;
    int          n_tests;
    int          cyc;
    int          k;
    int          seed;

    alz_core alz_core_i (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .nvm_we(nvm_we), .nvm_addr(nvm_addr),
        .nvm_data(nvm_data), .raw_valid(raw_valid), .raw_angle(raw_angle),
        .angle_out(angle_out), .angle_valid(angle_valid));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Hang guard, generous against about 630 cycles of traffic
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            conclude();
        end
    end

    // Results are checked in arrival order; a spare pulse finds the queue empty
    always @(posedge clock) begin
        if (angle_valid === 1'b1) begin
            if (q.size() == 0) chk(32'h1, 32'h0);
            else chk({20'h0, angle_out}, {20'h0, q.pop_front()});
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clock);
        hsel   <= 1'b1;
        haddr  <= {20'h0, a};
        htrans <= alz_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        hsize  <= 3'h2;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic nvm(input logic [11:0] a, input logic [15:0] d);
        @(posedge clock);
        nvm_we   <= 1'b1;
        nvm_addr <= a;
        nvm_data <= d;
        @(posedge clock);
        nvm_we   <= 1'b0;
    endtask

    // Linearize first, then subtract offset and wrap to twelve bits
    function automatic logic [11:0] model(input logic [11:0] v);
        int s;
        int l;
        s = int'(v[11:8]);
        if (mode != 0) l = int'(v) + hc;
        else l = pts[s] + ((pts[s+1] - pts[s]) * int'(v[7:0])) / 256;
        return 12'(l - off);
    endfunction

    task automatic samp(input logic [11:0] v, input int hold);
        @(posedge clock);
        raw_valid <= 1'b1;
        raw_angle <= v;
        q.push_back(model(v));
        repeat (hold) @(posedge clock);
        raw_valid <= 1'b0;
        raw_angle <= v ^ 12'h0f0;
        repeat (6) @(posedge clock);
        rdchk(alz_pkg::OFS_RESULT, {20'h0, model(v)});
        rdchk(alz_pkg::OFS_RAW, {20'h0, v});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'hbb2c;
        {hsel, hwrite, nvm_we, raw_valid, haddr, hwdata, htrans} = '0;
        {hsize, nvm_addr, nvm_data, raw_angle} = '0;
        rst = 1'b1;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        rdchk(12'h080, 32'h0);
        for (k = 0; k < 17; k++) begin
            pts[k] = k * 128;
            nvm(12'h100 + 12'(k), 16'(k * 128));
        end
        nvm(12'h306, 16'hf123);
        off = 32'h123;
        mode = 0;
        bus(1'b1, alz_pkg::OFS_CTRL, 32'h0);
        samp(12'h000, 1);
        samp(12'hffe, 1);
        samp(12'h0fe, 1);
        // Second cycle of valid falls in busy and must be dropped
        samp(12'h800, 2);
        $display("Segmented and offset test done");
        bus(1'b1, alz_pkg::OFS_SEG + 12'h00c, 32'd512);
        pts[3] = 512;
        bus(1'b1, alz_pkg::OFS_SEG, 32'h0);
        pts[0] = 0;
        samp(12'h380, 1);
        samp(12'h2fe, 1);
        bus(1'b1, alz_pkg::OFS_ZOFF, 32'h7ff);
        off = 32'h7ff;
        samp(12'h100, 1);
        $display("Override test done");
        for (k = 0; k < 11; k++) begin
            bus(1'b1, alz_pkg::OFS_HAMP + 12'(4 * k), 32'h0);
            bus(1'b1, alz_pkg::OFS_HPH + 12'(4 * k), 32'($random(seed)) & 32'hfff);
        end
        bus(1'b1, alz_pkg::OFS_HOFS, 32'h0);
        mode = 1;
        bus(1'b1, alz_pkg::OFS_CTRL, 32'h1);
        rdchk(alz_pkg::OFS_CTRL, 32'h1);
        samp(12'h380, 1);
        // First harmonic alone: full negative swing at zero, zero crossing at a quarter turn
        bus(1'b1, alz_pkg::OFS_HPH, 32'h0);
        bus(1'b1, alz_pkg::OFS_HAMP, 32'h5);
        hc = 5;
        samp(12'h000, 1);
        hc = 0;
        samp(12'h400, 1);
        bus(1'b1, alz_pkg::OFS_HAMP, 32'h0);
        $display("Harmonic test done");
        for (k = 0; k < 24; k++) begin
            if (k % 8 == 0) begin
                mode = 1 - mode;
                bus(1'b1, alz_pkg::OFS_CTRL, 32'(mode));
            end
            x = 12'($random(seed)) & 12'hffe;
            samp(x, 1);
        end
        chk(32'(q.size()), 32'h0);
        $display("Random test done");
        conclude();
    end
endmodule
